// ### sfs_sampler.sv
`timescale 1ns/1ps
module sfs_sampler #(
	parameter int NUM_PORTS = 8
) (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic [sfs_pkg::ADDR_W-1:0] paddr,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [31:0]              pwdata,
	output logic [31:0]                   prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire sfs_pkg::sfs_cand_t       cand,
	output sfs_pkg::sfs_copy_t            copy,
	output logic [sfs_pkg::EVT_W-1:0]     stat_evt,
	output logic [sfs_pkg::PORT_W-1:0]    stat_port,
	output logic                          irq
);
	import sfs_pkg::*;

	typedef struct packed {
		logic [31:0]                        prdata;
		logic                               pready;
		logic                               pslverr;
		logic                               global_on;
		logic                               id_on;
		logic [QSEL_W-1:0]                  qsel;
		logic [EVT_W-1:0]                   sticky;
		logic [EVT_W-1:0]                   irq_en;
		logic [EVT_W-1:0]                   stat_mask;
		logic                               irq;
		logic [NUM_PORTS-1:0][CTRL_W-1:0]   ctrl;
		logic [NUM_PORTS-1:0][31:0]         taken;
		logic [NUM_PORTS-1:0][31:0]         cands;
		logic [31:0]                        lfsr;
		sfs_copy_t                          copy;
		logic [EVT_W-1:0]                   stat_evt;
		logic [PORT_W-1:0]                  stat_port;
	} sfs_state_t;

	sfs_state_t s_reg;
	sfs_state_t s_next;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic              setup;
		logic              wr;
		logic [PORT_W-1:0] ridx;
		logic              in_port;
		logic              mapped;
		logic [31:0]       rdat;
		logic [EVT_W-1:0]  ev;
		logic [EVT_W-1:0]  clr;
		logic [CTRL_W-1:0] c;
		logic              dir_on;
		logic              take;
		logic [31:0]       n_cand;
		logic [31:0]       n_taken;
		setup   = psel & ~penable;
		wr      = psel & penable & s_reg.pready & pwrite;
		ridx    = paddr[9:4];
		in_port = (paddr[11:10] == PORT_REGION) &&
			(32'(ridx) < NUM_PORTS);
		mapped  = 1'b1;
		rdat    = 32'h0000_0000;
		ev      = '0;
		clr     = '0;
		c       = '0;
		dir_on  = 1'b0;
		take    = 1'b0;
		n_cand  = 32'h0000_0000;
		n_taken = 32'h0000_0000;
		s_next  = s_reg;

		// Free-running draw; advancing every cycle keeps draws uncorrelated
		if (s_reg.lfsr[0]) begin
			s_next.lfsr = (s_reg.lfsr >> 1) ^ LFSR_TAPS;
		end else begin
			s_next.lfsr = s_reg.lfsr >> 1;
		end

		// Register read decode, answered in the access cycle
		case (paddr)
			OFF_COMMON: begin
				rdat[COMMON_ON_BIT] = s_reg.global_on;
				rdat[COMMON_ID_BIT] = s_reg.id_on;
			end
			OFF_QSEL:      rdat[QSEL_W-1:0] = s_reg.qsel;
			OFF_STICKY:    rdat[EVT_W-1:0]  = s_reg.sticky;
			OFF_STICKY_CL: rdat = 32'h0000_0000;
			OFF_IRQ_EN:    rdat[EVT_W-1:0]  = s_reg.irq_en;
			OFF_STAT_MASK: rdat[EVT_W-1:0]  = s_reg.stat_mask;
			default: begin
				if (in_port) begin
					case (paddr[3:0])
						OFF_P_CTRL:  rdat[CTRL_W-1:0] = s_reg.ctrl[ridx];
						OFF_P_TAKEN: rdat = s_reg.taken[ridx];
						OFF_P_CAND:  rdat = s_reg.cands[ridx];
						default:     mapped = 1'b0;
					endcase
				end else begin
					mapped = 1'b0;
				end
			end
		endcase

		s_next.pready  = setup;
		s_next.pslverr = setup & ~mapped;
		if (setup && !pwrite) begin
			s_next.prdata = rdat;
		end

		// Register writes; tallies are read-only
		if (wr && mapped) begin
			case (paddr)
				OFF_COMMON: begin
					s_next.global_on = pwdata[COMMON_ON_BIT];
					s_next.id_on     = pwdata[COMMON_ID_BIT];
				end
				OFF_QSEL:      s_next.qsel = pwdata[QSEL_W-1:0];
				OFF_STICKY:    clr = pwdata[EVT_W-1:0];
				OFF_STICKY_CL: clr = pwdata[EVT_W-1:0];
				OFF_IRQ_EN:    s_next.irq_en = pwdata[EVT_W-1:0];
				OFF_STAT_MASK: s_next.stat_mask = pwdata[EVT_W-1:0];
				default: begin
					if (in_port && paddr[3:0] == OFF_P_CTRL) begin
						s_next.ctrl[ridx] = pwdata[CTRL_W-1:0];
					end
				end
			endcase
		end

		////////////////////////////////////////////////////////////////////
		// Candidate handling, one frame per cycle at most
		s_next.copy.valid = 1'b0;
		s_next.stat_evt   = '0;
		if (cand.valid && s_reg.global_on &&
			(32'(cand.port) < NUM_PORTS)) begin
			c = s_reg.ctrl[cand.port];
			// Each direction gated by its own bit, rate shared
			dir_on = cand.tx ? c[DIR_TX_BIT] : c[DIR_RX_BIT];
			if (dir_on) begin
				n_cand = s_reg.cands[cand.port] + 32'h0000_0001;
				s_next.cands[cand.port] = n_cand;
				ev[EVT_CAND] = 1'b1;
				// Rate 32768 or more always takes; 0 never
				take = {1'b0, s_reg.lfsr[14:0]} < c[RATE_W-1:0];
				n_taken = s_reg.taken[cand.port];
				if (take) begin
					n_taken = n_taken + 32'h0000_0001;
					s_next.taken[cand.port] = n_taken;
					ev[cand.tx ? EVT_TX_COPY : EVT_RX_COPY] = 1'b1;
					// Forwarding untouched; this is an extra copy
					s_next.copy.valid = 1'b1;
					s_next.copy.tx    = cand.tx;
					s_next.copy.port  = cand.port;
					s_next.copy.frame = cand.frame;
					s_next.copy.queue = s_reg.qsel;
					s_next.copy.sampled_copy_flag = 1'b1;
					if (s_reg.id_on) begin
						s_next.copy.stamp = {cand.port,
							n_cand[STAMP_ID_LSB-STAMP_CAND_LSB-1:0],
							n_taken[7:0]};
					end else begin
						s_next.copy.stamp = {
							n_cand[31-STAMP_CAND_LSB:0],
							n_taken[7:0]};
					end
				end
			end
		end

		// A new event beats a clear in the same cycle
		s_next.sticky    = (s_reg.sticky & ~clr) | ev;
		s_next.stat_evt  = ev & s_reg.stat_mask;
		s_next.stat_port = cand.port;
		s_next.irq       = |(s_next.sticky & s_next.irq_en);
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg      <= '0;
			s_reg.lfsr <= LFSR_SEED;
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata    = s_reg.prdata;
	assign pready    = s_reg.pready;
	assign pslverr   = s_reg.pslverr;
	assign copy      = s_reg.copy;
	assign stat_evt  = s_reg.stat_evt;
	assign stat_port = s_reg.stat_port;
	assign irq       = s_reg.irq;

endmodule : sfs_sampler

// ### sfs_pkg.sv
package sfs_pkg;

	localparam int PORT_W  = 6;
	localparam int FRAME_W = 16;
	localparam int QSEL_W  = 3;
	localparam int ADDR_W  = 12;
	localparam int RATE_W  = 16;
	localparam int CTRL_W  = 18;
	localparam int EVT_W   = 3;

	// Global register byte offsets
	localparam logic [11:0] OFF_COMMON    = 12'h000;
	localparam logic [11:0] OFF_QSEL      = 12'h004;
	localparam logic [11:0] OFF_STICKY    = 12'h008;
	localparam logic [11:0] OFF_STICKY_CL = 12'h00C;
	localparam logic [11:0] OFF_IRQ_EN    = 12'h010;
	localparam logic [11:0] OFF_STAT_MASK = 12'h014;
	// Per-port block: base + 16 * port
	localparam logic [1:0]  PORT_REGION   = 2'h1;
	localparam logic [3:0]  OFF_P_CTRL    = 4'h0;
	localparam logic [3:0]  OFF_P_TAKEN   = 4'h4;
	localparam logic [3:0]  OFF_P_CAND    = 4'h8;

	// Field positions
	localparam int COMMON_ON_BIT  = 0;
	localparam int COMMON_ID_BIT  = 1;
	localparam int DIR_RX_BIT     = 16;
	localparam int DIR_TX_BIT     = 17;
	localparam int EVT_CAND       = 0;
	localparam int EVT_RX_COPY    = 1;
	localparam int EVT_TX_COPY    = 2;
	localparam int STAMP_ID_LSB   = 26;
	localparam int STAMP_CAND_LSB = 8;

	// LFSR value after reset, and its feedback taps
	localparam logic [31:0] LFSR_SEED = 32'h1ACE_B00C;
	localparam logic [31:0] LFSR_TAPS = 32'h8020_0003;

	typedef struct packed {
		logic               valid;
		logic               tx;
		logic [PORT_W-1:0]  port;
		logic [FRAME_W-1:0] frame;
	} sfs_cand_t;

	typedef struct packed {
		logic               valid;
		logic               tx;
		logic [PORT_W-1:0]  port;
		logic [FRAME_W-1:0] frame;
		logic [QSEL_W-1:0]  queue;
		logic               sampled_copy_flag;
		logic [31:0]        stamp;
	} sfs_copy_t;

endpackage : sfs_pkg

// ### sfs_sampler_properties.sv
`timescale 1ns/1ps
module sfs_sampler_properties #(
	parameter int NUM_PORTS = 8
) (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire sfs_pkg::sfs_cand_t cand,
	input wire sfs_pkg::sfs_copy_t copy,
	input wire logic [2:0]         stat_evt,
	input wire logic [5:0]         stat_port,
	input wire logic               irq
);
	import sfs_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_PREADY: assert property (psel && !penable |=> pready)
		else $error("pready not in access cycle");
	AST_SLVERR: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_COPY: assert property (copy.valid |-> $past(cand.valid)
		&& $past(cand.port) < NUM_PORTS) else $error("copy without cause");
	AST_SRC: assert property (copy.valid |-> copy.port == $past(cand.port)
		&& copy.tx == $past(cand.tx)) else $error("copy source wrong");
	AST_FLAG: assert property (copy.valid |-> copy.sampled_copy_flag)
		else $error("copy flag missing");
	AST_TALLY: assert property (copy.valid && $past(copy.valid)
		&& copy.port == $past(copy.port) |->
		{copy.stamp[15:8] - $past(copy.stamp[15:8]),
		copy.stamp[7:0] - $past(copy.stamp[7:0])} == 16'h0101)
		else $error("stamp tallies not stepping");
	AST_EVT_RX: assert property (stat_evt[EVT_RX_COPY] |->
		copy.valid && !copy.tx) else $error("rx event wrong");
	AST_EVT_TX: assert property (stat_evt[EVT_TX_COPY] |->
		copy.valid && copy.tx) else $error("tx event wrong");
	AST_EVT_CAND: assert property (stat_evt[EVT_CAND] |->
		$past(cand.valid) && stat_port == $past(cand.port))
		else $error("candidate event wrong");
	cover property (copy.valid && copy.tx);
	cover property (copy.valid && !copy.tx);
	cover property ($rose(irq));
	cover property (pslverr);
endmodule : sfs_sampler_properties
////////////////////////////////////////
bind sfs_sampler sfs_sampler_properties #(.NUM_PORTS(NUM_PORTS))
	sfs_sampler_properties_inst (.pclk, .presetn, .psel, .penable, .pready,
	.pslverr, .cand, .copy, .stat_evt, .stat_port, .irq);

// ### sfs_pipe_model.sv
`timescale 1ns/1ps
module sfs_pipe_model (
	input  wire logic         pclk,
	output sfs_pkg::sfs_cand_t cand
);
	import sfs_pkg::*;
	initial cand = '0;
	// Valid held high one cycle per frame, n frames back to back, then dropped
	task automatic offer(input logic tx, input logic [5:0] p, input int n);
		repeat (n) begin
			@(posedge pclk);
			cand <= '{1'b1, tx, p, cand.frame + 16'h0001};
		end
		@(posedge pclk);
		cand.valid <= 1'b0;
	endtask : offer
endmodule : sfs_pipe_model

// ### test_statistical_frame_sampler.sv
`timescale 1ns/1ps
module test_statistical_frame_sampler;
	import sfs_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        irq, err, id_on;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic [1:0]  dirs;
	logic [2:0]  stat_evt, smask;
	logic [5:0]  stat_port;
	sfs_cand_t   cand, prev;
	sfs_copy_t   copy;
	int          miscompares, n_compared, ntaken, ncand;
	sfs_sampler #(.NUM_PORTS(8)) sfs_sampler_inst (.pclk, .presetn, .paddr,
		.psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.cand, .copy, .stat_evt, .stat_port, .irq);
	sfs_pipe_model sfs_pipe_model_inst (.pclk, .cand);
	////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		logic ok;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		// Looked at before the edge, so the answer has settled
		do begin
			@(negedge pclk);
			ok = pready;
			rdata = prdata;
			err = pslverr;
			@(posedge pclk);
		end while (ok !== 1'b1);
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rdata, exp);
	endtask : rd
	function automatic logic [11:0] pa(input int p, input logic [3:0] o);
		return {PORT_REGION, 6'(p), o};
	endfunction : pa
	task automatic conclude();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	// Expected stamps; only port 2 ever gets copies
	// Mid-cycle, away from the edge that launches the copy
	always @(negedge pclk) begin
		if (copy.valid === 1'b1) begin
			ntaken++;
			check({copy.queue, copy.sampled_copy_flag, copy.port, copy.stamp[7:0]},
				{3'h5, 1'b1, 6'h02, ntaken[7:0]});
			check(copy.stamp[31:8], id_on ? {6'h02, ncand[17:0]}
				: ncand[23:0]);
			check({copy.tx, copy.frame}, {prev.tx, prev.frame});
			check({stat_port, stat_evt}, {6'h02,
				{copy.tx, ~copy.tx, 1'b1} & smask});
		end
		if (cand.valid && cand.port == 6'h02 && dirs[cand.tx])
			ncand++;
		prev = cand;
	end
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		#100us;
		miscompares++;
		conclude();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, id_on, dirs, smask} = '0;
		presetn = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFF_COMMON, 32'h0);
		rd(pa(2, OFF_P_CTRL), 32'h0);
		apb(1'b0, 12'hFFC, 32'h0);
		check(err, 1'b1);
		apb(1'b1, pa(2, OFF_P_TAKEN), 32'hFF);
		rd(pa(2, OFF_P_TAKEN), 32'h0);
		$display("test 1 done");
		{id_on, dirs} = 3'b101;
		apb(1'b1, OFF_COMMON, 32'h3);
		apb(1'b1, OFF_QSEL, 32'h5);
		apb(1'b1, OFF_IRQ_EN, 32'h7);
		smask = 3'h7;
		apb(1'b1, OFF_STAT_MASK, 32'h7);
		apb(1'b1, pa(2, OFF_P_CTRL), 32'h0001_8000);
		rd(pa(2, OFF_P_CTRL), 32'h0001_8000);
		sfs_pipe_model_inst.offer(1'b0, 6'h02, 3);
		sfs_pipe_model_inst.offer(1'b1, 6'h02, 2);
		rd(pa(2, OFF_P_TAKEN), 32'h3);
		rd(pa(2, OFF_P_CAND), 32'h3);
		rd(OFF_STICKY, 32'h3);
		check(irq, 1'b1);
		apb(1'b1, OFF_STICKY_CL, 32'h7);
		rd(OFF_STICKY, 32'h0);
		check(irq, 1'b0);
		$display("test 2 done");
		dirs = 2'b10;
		apb(1'b1, pa(2, OFF_P_CTRL), 32'h0002_8000);
		sfs_pipe_model_inst.offer(1'b1, 6'h02, 2);
		sfs_pipe_model_inst.offer(1'b0, 6'h02, 1);
		sfs_pipe_model_inst.offer(1'b1, 6'h09, 1);
		rd(pa(2, OFF_P_TAKEN), 32'h5);
		rd(OFF_STICKY, 32'h5);
		apb(1'b1, OFF_STICKY, 32'h1);
		rd(OFF_STICKY, 32'h4);
		dirs = 2'b11;
		apb(1'b1, pa(2, OFF_P_CTRL), 32'h0003_0000);
		sfs_pipe_model_inst.offer(1'b0, 6'h02, 2);
		sfs_pipe_model_inst.offer(1'b1, 6'h02, 2);
		rd(pa(2, OFF_P_TAKEN), 32'h5);
		rd(pa(2, OFF_P_CAND), 32'h9);
		$display("test 3 done");
		id_on = 1'b0;
		apb(1'b1, OFF_COMMON, 32'h1);
		apb(1'b1, pa(2, OFF_P_CTRL), 32'h0003_8000);
		smask = 3'h5;
		apb(1'b1, OFF_STAT_MASK, 32'h5);
		sfs_pipe_model_inst.offer(1'b0, 6'h02, 1);
		rd(pa(2, OFF_P_TAKEN), 32'h6);
		dirs = 2'b00;
		apb(1'b1, OFF_COMMON, 32'h0);
		sfs_pipe_model_inst.offer(1'b0, 6'h02, 2);
		rd(pa(2, OFF_P_CAND), 32'hA);
		rd(pa(3, OFF_P_CAND), 32'h0);
		$display("test 4 done");
		conclude();
	end
endmodule : test_statistical_frame_sampler
